// ### verilog/pps_top.sv
/*
  Peripheral pin selector: output code per remappable pin, input maps for
  the SPI two select and CAN one receive inputs, reached over Avalon-MM.
  Assumes peripheral and pad signals are synchronous to MCLK.
*/
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
module pps_top
  import pps_pkg::*;
(
  // Clock and reset
  input  wire logic                   MCLK,
  input  wire logic                   RESET,
  // Avalon-MM slave
  input  wire logic [7:0]             AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic      [31:0]            AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  // Peripheral outputs
  input  wire logic                   UART_ONE_TRANSMIT,
  input  wire logic                   UART_TWO_TRANSMIT,
  input  wire logic                   SPI_TWO_DATA_OUT,
  input  wire logic                   SPI_TWO_CLOCK_OUT,
  input  wire logic                   SPI_TWO_PERIPHERAL_SELECT,
  input  wire logic                   CAN_ONE_TRANSMIT,
  input  wire logic [3:0]             COMPARE_OUTPUT,
  input  wire logic [4:0]             COMPARATOR_RESULT,
  input  wire logic                   PWM_TIME_BASE_SYNC,
  input  wire logic                   REFERENCE_CLOCK_OUTPUT,
  input  wire logic                   NIBBLE_TRANSMITTER_ONE,
  input  wire logic                   NIBBLE_TRANSMITTER_TWO,
  // Pads
  input  wire logic [NUM_PINS-1:0]    PORT_LATCH_OUT,
  input  wire logic [NUM_PINS-1:0]    PORT_DRIVE_EN,
  input  wire logic [PIN_IN_W-1:0]    REMAPPABLE_PIN_IN,
  output logic      [NUM_PINS-1:0]    REMAPPABLE_PIN_OUT,
  output logic      [NUM_PINS-1:0]    REMAPPABLE_PIN_OE,
  output logic      [NUM_PINS-1:0]    PIN_ROUTED,
  // Peripheral inputs
  output logic                        SPI_TWO_SELECT_IN,
  output logic                        CAN_ONE_RECEIVE
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [ISEL_W-1:0]               spi2_select_source_code;
    logic [ISEL_W-1:0]               can1_receive_source_code;
    logic [NUM_PINS-1:0][CODE_W-1:0] output_function_code;
    logic                            ack;
    logic [31:0]                     rdata;
    logic [NUM_PINS-1:0]             pin_out;
    logic [NUM_PINS-1:0]             pin_oe;
    logic                            spi_sel_in;
    logic                            can_rx_in;
  } pps_state_t;

  pps_state_t st_reg;
  pps_state_t st_next;

  logic [NUM_SRC-1:0]  src_vec;
  logic [NUM_PINS-1:0] routed;
  logic [NUM_PINS-1:0] drive;

  // Bit 19 unused spare, held low
  assign src_vec = {1'b0, NIBBLE_TRANSMITTER_TWO, NIBBLE_TRANSMITTER_ONE,
                    COMPARATOR_RESULT[4], COMPARATOR_RESULT[3],
                    REFERENCE_CLOCK_OUTPUT, PWM_TIME_BASE_SYNC,
                    COMPARATOR_RESULT[2:0], COMPARE_OUTPUT,
                    CAN_ONE_TRANSMIT, SPI_TWO_PERIPHERAL_SELECT,
                    SPI_TWO_CLOCK_OUT, SPI_TWO_DATA_OUT,
                    UART_TWO_TRANSMIT, UART_ONE_TRANSMIT};

  // ----------------------------------------
  // Per-pin output selectors
  // ----------------------------------------
  // one source may feed any number of pins
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pps_map_if mi ();
    assign mi.code    = st_reg.output_function_code[p];
    assign mi.sources = src_vec;
    assign routed[p]  = mi.routed;
    assign drive[p]   = mi.drive;
    pps_out_mux u_mux (
      .m (mi.mux)
    );
  end

  // ----------------------------------------
  // Input selection
  // ----------------------------------------
  function automatic logic pick_input(input logic [ISEL_W-1:0] c,
                                      input logic [4:0] cmp,
                                      input logic [PIN_IN_W-1:0] pins);
    if (c == IS_GROUND) begin
      pick_input = 1'b0;
    end else if (c == IS_CMPR1) begin
      pick_input = cmp[0];
    end else begin
      pick_input = pins[c];
    end
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic int out_slot(input logic [7:0] a);
    if (a >= OUT_MAP_BASE_OFS && a < OUT_MAP_BASE_OFS + 8'(4 * NUM_PINS) && a[1:0] == 2'b00) begin
      out_slot = int'((a - OUT_MAP_BASE_OFS) >> 2);
    end else begin
      out_slot = -1;
    end
  endfunction

  int slot;

  always_comb begin
    st_next = st_reg;
    slot    = out_slot(AVS_ADDRESS);
    st_next.ack = 1'b0;
    // One wait cycle, then the ack cycle completes the access
    if ((AVS_READ || AVS_WRITE) && !st_reg.ack) begin
      st_next.ack = 1'b1;
    end
    if (AVS_WRITE && !st_reg.ack && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == SPI2_SELECT_INPUT_MAP_OFS) begin
        st_next.spi2_select_source_code = AVS_WRITEDATA[7:0];
      end
      if (AVS_ADDRESS == CAN1_RECEIVE_INPUT_MAP_OFS) begin
        st_next.can1_receive_source_code = AVS_WRITEDATA[7:0];
      end
      if (slot >= 0) begin
        st_next.output_function_code[slot[2:0]] = AVS_WRITEDATA[CODE_W-1:0];
      end
    end
    if (AVS_READ && !st_reg.ack) begin
      st_next.rdata = UNMAPPED_READ;
      if (AVS_ADDRESS == SPI2_SELECT_INPUT_MAP_OFS) begin
        st_next.rdata[7:0] = st_reg.spi2_select_source_code;
      end else if (AVS_ADDRESS == CAN1_RECEIVE_INPUT_MAP_OFS) begin
        st_next.rdata[7:0] = st_reg.can1_receive_source_code;
      end else if (slot >= 0) begin
        st_next.rdata[CODE_W-1:0] = st_reg.output_function_code[slot[2:0]];
        st_next.rdata[8] = routed[slot[2:0]];
      end
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      st_next.pin_out[p] = routed[p] ? drive[p] : PORT_LATCH_OUT[p];
      st_next.pin_oe[p]  = routed[p] ? 1'b1 : PORT_DRIVE_EN[p];
    end
    // one pin may feed both inputs
    st_next.spi_sel_in = pick_input(st_reg.spi2_select_source_code,
                                    COMPARATOR_RESULT, REMAPPABLE_PIN_IN);
    st_next.can_rx_in  = pick_input(st_reg.can1_receive_source_code,
                                    COMPARATOR_RESULT, REMAPPABLE_PIN_IN);
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign AVS_WAITREQUEST    = (AVS_READ || AVS_WRITE) && !st_reg.ack;
  assign AVS_READDATA       = st_reg.rdata;
  assign REMAPPABLE_PIN_OUT = st_reg.pin_out;
  assign REMAPPABLE_PIN_OE  = st_reg.pin_oe;
  assign PIN_ROUTED         = routed;
  assign SPI_TWO_SELECT_IN  = st_reg.spi_sel_in;
  assign CAN_ONE_RECEIVE    = st_reg.can_rx_in;

endmodule

// ### pkg/pps_pkg.sv
/*
  Constants, register map and field layouts for the peripheral pin selector.
  Assumes a 32-bit Avalon-MM slave port with word addresses in bytes.
*/
// Overview of operation
// - Each remappable pin has a six-bit code; zero leaves ordinary port logic driving.
// - Code 000001 routes the first UART transmit, 000011 the second.
// - Codes 001000..001010 route SPI two data, clock and peripheral select.
// - Code 001110 routes the first CAN transmit line to the pin.
// - Codes 010000..010011 route compare outputs one to four in order.
// - Codes 011000..011010 route comparator results one, two and three.
// - Codes 110010 and 110011 route comparator results four and five.
// - Code 101101 routes the PWM primary time base sync output.
// - Code 110001 routes the reference clock output.
// - Codes 111001 and 111010 route nibble transmitters one and two.
// - No interlock: every map register writes and acts independently.
// - Many-to-one and one-to-many mappings are all accepted.
// - SPI two select map: eight-bit code in bits 7-0, bits 15-8 read zero.
// - CAN one receive map: eight-bit code in bits 7-0, upper byte reads zero.
// - Input code 0 is ground, 1 comparator one, 10110101 remappable input 181.
package pps_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_PINS   = 8;
  localparam int CODE_W     = 6;
  localparam int ISEL_W     = 8;
  localparam int NUM_SRC    = 20;
  localparam int PIN_IN_W   = 256;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] SPI2_SELECT_INPUT_MAP_OFS  = 8'h00;
  localparam logic [7:0] CAN1_RECEIVE_INPUT_MAP_OFS = 8'h04;
  localparam logic [7:0] OUT_MAP_BASE_OFS           = 8'h10;
  localparam logic [31:0] UNMAPPED_READ             = 32'h0000_0000;
  localparam logic [ISEL_W-1:0] ISEL_RESET          = 8'h00;
  localparam logic [CODE_W-1:0] OCODE_RESET         = 6'h00;

  // ----------------------------------------
  // Output function codes
  // ----------------------------------------
  localparam logic [CODE_W-1:0] OF_DEFAULT   = 6'h00;
  localparam logic [CODE_W-1:0] OF_UART1_TX  = 6'h01;
  localparam logic [CODE_W-1:0] OF_UART2_TX  = 6'h03;
  localparam logic [CODE_W-1:0] OF_SPI2_DOUT = 6'h08;
  localparam logic [CODE_W-1:0] OF_SPI2_CLK  = 6'h09;
  localparam logic [CODE_W-1:0] OF_SEL2      = 6'h0A;
  localparam logic [CODE_W-1:0] OF_CANTX     = 6'h0E;
  localparam logic [CODE_W-1:0] OF_CMPO1     = 6'h10;
  localparam logic [CODE_W-1:0] OF_CMPO2     = 6'h11;
  localparam logic [CODE_W-1:0] OF_CMPO3     = 6'h12;
  localparam logic [CODE_W-1:0] OF_CMPO4     = 6'h13;
  localparam logic [CODE_W-1:0] OF_CMPR1     = 6'h18;
  localparam logic [CODE_W-1:0] OF_CMPR2     = 6'h19;
  localparam logic [CODE_W-1:0] OF_CMPR3     = 6'h1A;
  localparam logic [CODE_W-1:0] OF_SYNC      = 6'h2D;
  localparam logic [CODE_W-1:0] OF_REFCLK    = 6'h31;
  localparam logic [CODE_W-1:0] OF_CMPR4     = 6'h32;
  localparam logic [CODE_W-1:0] OF_CMPR5     = 6'h33;
  localparam logic [CODE_W-1:0] OF_NIB1      = 6'h39;
  localparam logic [CODE_W-1:0] OF_NIB2      = 6'h3A;

  // ----------------------------------------
  // Input selector codes
  // ----------------------------------------
  localparam logic [ISEL_W-1:0] IS_GROUND   = 8'h00;
  localparam logic [ISEL_W-1:0] IS_CMPR1    = 8'h01;
  localparam logic [ISEL_W-1:0] IS_PIN181   = 8'hB5;

  typedef logic [CODE_W-1:0] pps_code_t;

endpackage

// ### pkg/pps_map_if.sv
/*
  Carries one pin's function code and the routed peripheral outputs.
  Assumes the selector top drives codes from flip-flops and sources straight from its input ports.
*/
interface pps_map_if;
  import pps_pkg::*;
  logic [CODE_W-1:0]  code;
  logic [NUM_SRC-1:0] sources;
  logic               routed;
  logic               drive;
  modport ctrl (output code, output sources, input routed, input drive);
  modport mux  (input code, input sources, output routed, output drive);
endinterface

// ### verilog/pps_out_mux.sv
/*
  Output-side selector for one remappable pin.
  Assumes the source vector order matches the order of the function codes.
*/
module pps_out_mux
  import pps_pkg::*;
(
  // Map link
  pps_map_if.mux m
);

  // ----------------------------------------
  // Code to source index
  // ----------------------------------------
  function automatic int code_index(input logic [CODE_W-1:0] c);
    unique case (c)
      OF_UART1_TX:  code_index = 0;
      OF_UART2_TX:  code_index = 1;
      OF_SPI2_DOUT: code_index = 2;
      OF_SPI2_CLK:  code_index = 3;
      OF_SEL2:      code_index = 4;
      OF_CANTX:     code_index = 5;
      OF_CMPO1:     code_index = 6;
      OF_CMPO2:     code_index = 7;
      OF_CMPO3:     code_index = 8;
      OF_CMPO4:     code_index = 9;
      OF_CMPR1:     code_index = 10;
      OF_CMPR2:     code_index = 11;
      OF_CMPR3:     code_index = 12;
      OF_SYNC:      code_index = 13;
      OF_REFCLK:    code_index = 14;
      OF_CMPR4:     code_index = 15;
      OF_CMPR5:     code_index = 16;
      OF_NIB1:      code_index = 17;
      OF_NIB2:      code_index = 18;
      default:      code_index = -1;
    endcase
  endfunction

  int idx;

  always_comb begin
    idx = code_index(m.code);
    if (idx < 0) begin
      m.routed = 1'b0;
      m.drive  = 1'b0;
    end else begin
      m.routed = 1'b1;
      m.drive  = m.sources[idx[4:0]];
    end
  end

endmodule

// ### bench/pps_top_props.sv
/*
  Checker of bus timing, pin routing and the select input map.
  Bound to pps_top; sees its ports only.
*/
module pps_top_props
  import pps_pkg::*;
(
  // Clock, reset, bus
  input wire logic                MCLK,
  input wire logic                RESET,
  input wire logic [7:0]          AVS_ADDRESS,
  input wire logic                AVS_READ,
  input wire logic                AVS_WRITE,
  input wire logic [31:0]         AVS_WRITEDATA,
  input wire logic [3:0]          AVS_BYTEENABLE,
  input wire logic [31:0]         AVS_READDATA,
  input wire logic                AVS_WAITREQUEST,
  // Pads and peripherals
  input wire logic [4:0]          COMPARATOR_RESULT,
  input wire logic [NUM_PINS-1:0] PORT_LATCH_OUT,
  input wire logic [NUM_PINS-1:0] PORT_DRIVE_EN,
  input wire logic [PIN_IN_W-1:0] REMAPPABLE_PIN_IN,
  input wire logic [NUM_PINS-1:0] REMAPPABLE_PIN_OUT,
  input wire logic [NUM_PINS-1:0] REMAPPABLE_PIN_OE,
  input wire logic [NUM_PINS-1:0] PIN_ROUTED,
  input wire logic                SPI_TWO_SELECT_IN
);
  // ----------
  // Helpers
  // ----------
  logic [7:0] sel_reg;
  logic       req;
  logic       done;
  logic       mapped;
  logic       exp_sel;
  assign req     = AVS_READ | AVS_WRITE;
  assign done    = req & ~AVS_WAITREQUEST;
  assign mapped  = AVS_ADDRESS == 8'h00 || AVS_ADDRESS == 8'h04 ||
                   (AVS_ADDRESS >= 8'h10 && AVS_ADDRESS <= 8'h2C && AVS_ADDRESS[1:0] == 2'h0);
  assign exp_sel = sel_reg == IS_GROUND ? 1'b0 :
                   sel_reg == IS_CMPR1 ? COMPARATOR_RESULT[0] : REMAPPABLE_PIN_IN[sel_reg];
  // Shadow taken at the same edge as the register itself
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) sel_reg <= 8'h00;
    else if (AVS_WRITE && AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == 8'h00)
      sel_reg <= AVS_WRITEDATA[7:0];
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  property p_wait_one;
    req && AVS_WAITREQUEST |=> done;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait");
  property p_wait_first;
    $rose(req) |-> AVS_WAITREQUEST;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  property p_idle;
    !req |-> !AVS_WAITREQUEST;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest while idle");
  property p_unmapped;
    done && AVS_READ && !mapped |-> AVS_READDATA == UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper;
    done && AVS_READ && AVS_ADDRESS < 8'h10 |-> AVS_READDATA[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("input map upper byte set");
  property p_status;
    done && AVS_READ && mapped && AVS_ADDRESS >= 8'h10 |->
      AVS_READDATA[8] == PIN_ROUTED[{~AVS_ADDRESS[4], AVS_ADDRESS[3:2]}];
  endproperty
  a_status: assert property (p_status) else $error("routed status mismatch");
  property p_port_out;
    !RESET |=> ((REMAPPABLE_PIN_OUT ^ $past(PORT_LATCH_OUT)) & ~$past(PIN_ROUTED)) == 8'h00;
  endproperty
  a_port_out: assert property (p_port_out) else $error("port value lost");
  property p_oe;
    !RESET |=> REMAPPABLE_PIN_OE == ($past(PORT_DRIVE_EN) | $past(PIN_ROUTED));
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_spi_sel;
    !RESET |=> SPI_TWO_SELECT_IN == $past(exp_sel);
  endproperty
  a_spi_sel: assert property (p_spi_sel) else $error("select input wrong source");
endmodule
bind pps_top pps_top_props u_props (.*);

// ### bench/pps_far.sv
/*
  Far side of the selector: peripheral outputs and pad levels.
  Assumes the bench clock and reset.
*/
module pps_far
  import pps_pkg::*;
(
  // Clock and reset
  input  wire logic                MCLK,
  input  wire logic                RESET,
  // Levels toward the selector
  output logic      [NUM_SRC-1:0]  src,
  output logic      [PIN_IN_W-1:0] pin_in,
  output logic      [NUM_PINS-1:0] latch,
  output logic      [NUM_PINS-1:0] pen
);
  // ----------
  // Pattern
  // ----------
  logic [NUM_SRC-1:0] lfsr_reg;
  // New value each cycle, so a wrong or stale route shows
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) lfsr_reg <= 20'h5A3C1;
    else lfsr_reg <= {lfsr_reg[18:0], lfsr_reg[19] ^ lfsr_reg[16]};
  end
  assign src    = lfsr_reg;
  assign pin_in = {16{lfsr_reg[15:0]}};
  assign latch  = lfsr_reg[17:10];
  assign pen    = lfsr_reg[9:2];
endmodule

// ### bench/tb.sv
/*
  Self-checking bench for the pin selector.
  Assumes the far-side model and the bound checker.
*/
module tb
  import pps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Wiring
  // ----------
  logic                MCLK;
  logic                RESET;
  logic [7:0]          addr;
  logic                rd;
  logic                wr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic [31:0]         rdata_q;
  logic [3:0]          be;
  logic                wait_req;
  logic                spi_in;
  logic                can_in;
  logic [NUM_SRC-1:0]  src;
  logic [PIN_IN_W-1:0] pin_in;
  logic [NUM_PINS-1:0] latch;
  logic [NUM_PINS-1:0] pen;
  logic [NUM_PINS-1:0] pout;
  logic [NUM_PINS-1:0] poe;
  logic [NUM_PINS-1:0] routed;
  int                  errors = 0;
  int                  n_checks = 0;
  localparam pps_code_t OC [19] = '{OF_UART1_TX, OF_UART2_TX, OF_SPI2_DOUT, OF_SPI2_CLK,
    OF_SEL2, OF_CANTX, OF_CMPO1, OF_CMPO2, OF_CMPO3, OF_CMPO4, OF_CMPR1, OF_CMPR2, OF_CMPR3,
    OF_SYNC, OF_REFCLK, OF_CMPR4, OF_CMPR5, OF_NIB1, OF_NIB2};
  pps_far far_u (.MCLK(MCLK), .RESET(RESET), .src(src), .pin_in(pin_in), .latch(latch),
    .pen(pen));
  pps_top dut_u (.MCLK(MCLK), .RESET(RESET), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .UART_ONE_TRANSMIT(src[0]), .UART_TWO_TRANSMIT(src[1]),
    .SPI_TWO_DATA_OUT(src[2]), .SPI_TWO_CLOCK_OUT(src[3]), .SPI_TWO_PERIPHERAL_SELECT(src[4]),
    .CAN_ONE_TRANSMIT(src[5]), .COMPARE_OUTPUT(src[9:6]),
    .COMPARATOR_RESULT({src[16:15], src[12:10]}), .PWM_TIME_BASE_SYNC(src[13]),
    .REFERENCE_CLOCK_OUTPUT(src[14]), .NIBBLE_TRANSMITTER_ONE(src[17]),
    .NIBBLE_TRANSMITTER_TWO(src[18]), .PORT_LATCH_OUT(latch), .PORT_DRIVE_EN(pen),
    .REMAPPABLE_PIN_IN(pin_in), .REMAPPABLE_PIN_OUT(pout), .REMAPPABLE_PIN_OE(poe),
    .PIN_ROUTED(routed), .SPI_TWO_SELECT_IN(spi_in), .CAN_ONE_RECEIVE(can_in));
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Waitrequest sampled at each rising edge until low, read data taken at the completing edge only
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] b);
    @(posedge MCLK);
    addr  <= a;
    wdata <= d;
    be    <= b;
    rd    <= !w;
    wr    <= w;
    do begin
      @(posedge MCLK);
    end while (wait_req !== 1'b0);
    rdata_q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic sel(logic [7:0] c);
    return c == IS_GROUND ? 1'b0 : c == IS_CMPR1 ? src[10] : pin_in[c];
  endfunction
  task automatic t_out();
    logic       e;
    logic [7:0] a;
    for (int k = 0; k < 19; k++) begin
      a = OUT_MAP_BASE_OFS + 8'(4 * (k % 8));
      bus(1'b1, a, 32'(OC[k]), 4'h1);
      bus(1'b0, a, 32'h0, 4'hF);
      chk("code", rdata_q, {23'h0, 3'b100, OC[k]});
      @(negedge MCLK);
      e = src[k];
      @(negedge MCLK);
      chk("pin", {pout[k % 8], poe[k % 8]}, {e, 1'b1});
    end
    bus(1'b1, 8'h10, 32'(OF_REFCLK), 4'h1);
    bus(1'b1, 8'h14, 32'(OF_REFCLK), 4'h1);
    @(negedge MCLK);
    e = src[14];
    @(negedge MCLK);
    chk("fan out", pout[1:0], {e, e});
    bus(1'b1, 8'h18, 32'h3F, 4'h1);
    bus(1'b0, 8'h18, 32'h0, 4'hF);
    chk("unused code", rdata_q[8], 1'b0);
  endtask
  task automatic t_in();
    logic [7:0] c [4] = '{IS_GROUND, IS_CMPR1, IS_PIN181, 8'h07};
    logic [1:0] e;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, {24'hFFFFFF, c[i]}, 4'hF);
      bus(1'b1, 8'h04, {24'hFFFFFF, c[3 - i]}, 4'hF);
      bus(1'b0, 8'h00, 32'h0, 4'hF);
      chk("select map", rdata_q, 32'(c[i]));
      bus(1'b0, 8'h04, 32'h0, 4'hF);
      chk("receive map", rdata_q, 32'(c[3 - i]));
      @(negedge MCLK);
      e = {sel(c[i]), sel(c[3 - i])};
      @(negedge MCLK);
      chk("inputs", {spi_in, can_in}, e);
    end
    bus(1'b1, 8'h00, 32'h33, 4'hE);
    bus(1'b1, 8'h08, 32'h33, 4'hF);
    bus(1'b0, 8'h00, 32'h0, 4'hF);
    chk("masked write", rdata_q, 32'h07);
  endtask
  task automatic close_out();
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge MCLK);
    errors++;
    close_out();
  end
  initial begin
    RESET = 1'b1;
    {rd, wr, addr, wdata, be} = '0;
    repeat (10) @(posedge MCLK);
    RESET <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0, 4'hF);
      chk("reset value", rdata_q, 32'h0);
    end
    t_out();
    t_in();
    // Second reset with maps loaded: they must clear
    @(posedge MCLK);
    RESET <= 1'b1;
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    bus(1'b0, SPI2_SELECT_INPUT_MAP_OFS, 32'h0, 4'hF);
    chk("select after reset", rdata_q, 32'h0);
    bus(1'b0, OUT_MAP_BASE_OFS, 32'h0, 4'hF);
    chk("code after reset", rdata_q, 32'h0);
    close_out();
  end
endmodule
